// File: core/ctu_regs.svh
// instruction field positions and opcode encodings for the conditional trap unit
`ifndef CTU_REGS_SVH
`define CTU_REGS_SVH
`define CTU_OPC_HI      31
`define CTU_OPC_LO      26
`define CTU_SRCA_HI     25
`define CTU_SRCA_LO     21
`define CTU_SRCB_HI     20
`define CTU_SRCB_LO     16
`define CTU_IMM_HI      15
`define CTU_IMM_LO      0
`define CTU_FUNC_HI     5
`define CTU_FUNC_LO     0
`define CTU_CODE_HI     15
`define CTU_CODE_LO     6
`define CTU_OPC_SPECIAL 6'h00
`define CTU_OPC_IMM_CLS 6'h01
`define CTU_FN_TLS      6'h32
`define CTU_FN_TLU      6'h33
`define CTU_FN_NEQ      6'h36
`define CTU_SEL_TLIS    5'h0a
`define CTU_SEL_TLIU    5'h0b
`define CTU_SEL_NEQI    5'h0e
`endif

// File: core/ctu_pkg.sv
// types for the conditional trap unit
package ctu_pkg;
	typedef enum logic [6:0] {
		CTU_OP_NONE = 7'b0000001,
		CTU_OP_LTS  = 7'b0000010,
		CTU_OP_LTU  = 7'b0000100,
		CTU_OP_NE   = 7'b0001000,
		CTU_OP_LTIS = 7'b0010000,
		CTU_OP_LTIU = 7'b0100000,
		CTU_OP_NEI  = 7'b1000000
	} ctu_op_type;
endpackage

// File: core/ctu_trap_unit.sv
// conditional trap evaluation: decode, compare, registered trap request
`include "ctu_regs.svh"

module ctu_trap_unit #(
	parameter int XLEN = 64
) (
	input  wire logic            CLK_SYS,
	input  wire logic            RESETN,
	input  wire logic            INSTR_VALID,
	input  wire logic [31:0]     INSTR_WORD,
	input  wire logic [XLEN-1:0] SOURCE_A,
	input  wire logic [XLEN-1:0] SOURCE_B,
	output logic                 TRAP_REQ,
	output logic                 TRAP_DONE
);
	// the immediate forms extend a 16-bit field, narrower words cannot hold it
	if (XLEN < 16) begin
		$error("XLEN must be at least 16");
	end

	// ==========================================================
	// decode
	logic [5:0]          opc;
	logic [5:0]          func;
	logic [4:0]          sel;
	logic                is_reg_class;
	logic                is_imm_class;
	logic [XLEN-1:0]     imm_ext;
	ctu_pkg::ctu_op_type op;

	assign opc  = INSTR_WORD[`CTU_OPC_HI:`CTU_OPC_LO];
	assign func = INSTR_WORD[`CTU_FUNC_HI:`CTU_FUNC_LO];
	assign sel  = INSTR_WORD[`CTU_SRCB_HI:`CTU_SRCB_LO];
	// a bubble never answers, whatever stale word is left on the bus
	assign is_reg_class = INSTR_VALID && (opc == `CTU_OPC_SPECIAL);
	assign is_imm_class = INSTR_VALID && (opc == `CTU_OPC_IMM_CLS);
	// sign extension gives both ends of the unsigned range
	assign imm_ext = {{(XLEN-16){INSTR_WORD[`CTU_IMM_HI]}},
		INSTR_WORD[`CTU_IMM_HI:`CTU_IMM_LO]};

	always_comb begin
		op = ctu_pkg::CTU_OP_NONE;
		// register forms decode on func only, code field unused
		if (is_reg_class) begin
			case (func)
				`CTU_FN_TLS: op = ctu_pkg::CTU_OP_LTS;
				`CTU_FN_TLU: op = ctu_pkg::CTU_OP_LTU;
				`CTU_FN_NEQ: op = ctu_pkg::CTU_OP_NE;
				default:     op = ctu_pkg::CTU_OP_NONE;
			endcase
		end else if (is_imm_class) begin
			// source b field is a selector here, source b itself goes unused
			case (sel)
				`CTU_SEL_TLIS: op = ctu_pkg::CTU_OP_LTIS;
				`CTU_SEL_TLIU: op = ctu_pkg::CTU_OP_LTIU;
				`CTU_SEL_NEQI: op = ctu_pkg::CTU_OP_NEI;
				default:       op = ctu_pkg::CTU_OP_NONE;
			endcase
		end
	end

	// ==========================================================
	// compare
	logic                lt_reg_signed;
	logic                lt_reg_unsigned;
	logic                ne_reg;
	logic                lt_imm_signed;
	logic                lt_imm_unsigned;
	logic                ne_imm;
	logic                cond;

	// both sides cast: one unsigned operand would turn the compare unsigned
	assign lt_reg_signed   = $signed(SOURCE_A) < $signed(SOURCE_B);
	assign lt_reg_unsigned = SOURCE_A < SOURCE_B;
	assign ne_reg          = SOURCE_A != SOURCE_B;
	assign lt_imm_signed   = $signed(SOURCE_A) < $signed(imm_ext);
	// extension first, then an unsigned compare over the full width
	assign lt_imm_unsigned = SOURCE_A < imm_ext;
	assign ne_imm          = SOURCE_A != imm_ext;
	// six comparators side by side: area traded for a short, flat select path

	always_comb begin
		cond = 1'b0;
		unique case (op)
			ctu_pkg::CTU_OP_LTS:  cond = lt_reg_signed;
			ctu_pkg::CTU_OP_LTU:  cond = lt_reg_unsigned;
			ctu_pkg::CTU_OP_NE:   cond = ne_reg;
			ctu_pkg::CTU_OP_LTIS: cond = lt_imm_signed;
			ctu_pkg::CTU_OP_LTIU: cond = lt_imm_unsigned;
			ctu_pkg::CTU_OP_NEI:  cond = ne_imm;
			ctu_pkg::CTU_OP_NONE: cond = 1'b0;
			default:              cond = 1'b0;
		endcase
	end

	// ==========================================================
	// registered answer, one cycle per instruction
	// no stall input: a word held valid answers again on every cycle
	logic                next_trap_req;
	logic                next_trap_done;

	always_comb begin
		next_trap_req  = cond;
		next_trap_done = (op != ctu_pkg::CTU_OP_NONE) && !cond;
	end

	// outputs straight from flops, so the exception logic sees no decode glitches
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			TRAP_REQ  <= 1'b0;
			TRAP_DONE <= 1'b0;
		end else begin
			TRAP_REQ  <= next_trap_req;
			TRAP_DONE <= next_trap_done;
		end
	end

	// ==========================================================
	// assertions: register forms
	AST_LTS: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h00 && func == 6'h32)
		|=> TRAP_REQ == ($signed($past(SOURCE_A)) < $signed($past(SOURCE_B))))
		else $error("signed register trap wrong");

	AST_LTU: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h00 && func == 6'h33)
		|=> TRAP_REQ == ($past(SOURCE_A) < $past(SOURCE_B)))
		else $error("unsigned register trap wrong");

	AST_NE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h00 && func == 6'h36)
		|=> TRAP_REQ == ($past(SOURCE_A) != $past(SOURCE_B)))
		else $error("not-equal register trap wrong");

	AST_CODE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h00 && func == 6'h36 && SOURCE_A == SOURCE_B
		&& INSTR_WORD[`CTU_CODE_HI:`CTU_CODE_LO] != 10'h000)
		|=> !TRAP_REQ && TRAP_DONE)
		else $error("code field changed the decision");

	AST_REG_OTHER: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h00 && func != 6'h32 && func != 6'h33 && func != 6'h36)
		|=> !TRAP_REQ && !TRAP_DONE)
		else $error("register form without trap function answered");

	// ==========================================================
	// assertions: immediate forms
	AST_LTIS: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h01 && sel == 5'h0a)
		|=> TRAP_REQ == ($signed($past(SOURCE_A)) < $signed($past(imm_ext))))
		else $error("signed immediate trap wrong");

	AST_LTIU: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h01 && sel == 5'h0b)
		|=> TRAP_REQ == ($past(SOURCE_A) < $past(imm_ext)))
		else $error("unsigned immediate trap wrong");

	AST_IMM_TOP: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h01 && sel == 5'h0b && INSTR_WORD[15]
		&& SOURCE_A[XLEN-1:16] != {(XLEN-16){1'b1}}) |=> TRAP_REQ)
		else $error("high immediate range not honoured");

	AST_IMM_LOW: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h01 && sel == 5'h0b && !INSTR_WORD[15]
		&& SOURCE_A[XLEN-1:15] != {(XLEN-15){1'b0}}) |=> !TRAP_REQ && TRAP_DONE)
		else $error("low immediate range not honoured");

	AST_NEI: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h01 && sel == 5'h0e)
		|=> TRAP_REQ == ($past(SOURCE_A) != $past(imm_ext)))
		else $error("not-equal immediate trap wrong");

	AST_SEL_OTHER: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc == 6'h01 && sel != 5'h0a && sel != 5'h0b && sel != 5'h0e)
		|=> !TRAP_REQ && !TRAP_DONE)
		else $error("immediate class without trap selector answered");

	// ==========================================================
	// assertions: answer shape
	AST_OTHER_OPC: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(INSTR_VALID && opc != 6'h00 && opc != 6'h01)
		|=> !TRAP_REQ && !TRAP_DONE)
		else $error("non-trap opcode answered");

	AST_ANSWER: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		op != ctu_pkg::CTU_OP_NONE |=> TRAP_REQ != TRAP_DONE)
		else $error("trap instruction without exactly one answer");

	AST_REQ_CAUSE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		TRAP_REQ |-> $past(INSTR_VALID))
		else $error("trap request with no instruction before it");

	AST_DONE_CAUSE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		TRAP_DONE |-> $past(INSTR_VALID))
		else $error("completion with no instruction before it");

	AST_IDLE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		!INSTR_VALID |=> !TRAP_REQ && !TRAP_DONE)
		else $error("answer without instruction");

	AST_EXCL: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		!(TRAP_REQ && TRAP_DONE))
		else $error("trap and completion together");

	// ==========================================================
	// coverage of the main scenarios
	COV_TRAP: cover property (@(posedge CLK_SYS) disable iff (!RESETN) TRAP_REQ);
	COV_DONE: cover property (@(posedge CLK_SYS) disable iff (!RESETN) TRAP_DONE);
	COV_B2B:  cover property (@(posedge CLK_SYS) disable iff (!RESETN) TRAP_REQ ##1 TRAP_REQ);
	COV_LTIU: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
		op == ctu_pkg::CTU_OP_LTIU && cond);
	COV_IMM_HIGH: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
		op == ctu_pkg::CTU_OP_LTIU && INSTR_WORD[15] && !cond);
endmodule

// File: tb/ctu_exc_model.sv
// exception-side partner: counts trap requests taken from the unit
module ctu_exc_model (
	input  wire logic CLK_SYS,
	input  wire logic RESETN,
	input  wire logic TRAP_REQ,
	output int        traps
);
	timeunit 1ns;
	timeprecision 1ns;
	// one exception per cycle with TRAP_REQ high, so a stretched pulse shows as extra traps
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			traps <= 0;
		else if (TRAP_REQ)
			traps <= traps + 1;
	end
endmodule

// File: tb/test_conditional_trap_unit.sv
// self-checking bench for the conditional trap unit
module test_conditional_trap_unit;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [63:0] M1 = 64'hffff_ffff_ffff_ffff;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        iv = 1'b0;
	logic [31:0] iw = 32'h0;
	logic [63:0] sa = 64'h0;
	logic [63:0] sb = 64'h0;
	logic        req;
	logic        done;
	int          traps;
	int          exp_traps = 0;
	int          err_total = 0;
	int          n_tests = 0;
	ctu_trap_unit i_ctu_trap_unit (.CLK_SYS(clk), .RESETN(rst_n), .INSTR_VALID(iv),
		.INSTR_WORD(iw), .SOURCE_A(sa), .SOURCE_B(sb), .TRAP_REQ(req), .TRAP_DONE(done));
	ctu_exc_model i_ctu_exc_model (.CLK_SYS(clk), .RESETN(rst_n), .TRAP_REQ(req), .traps(traps));
	// ====
	// helpers
	task cmp(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cmp_count(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one instruction with an idle cycle after it; e is {trap, done}
	task ex(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b,
		input logic [1:0] e);
		@(posedge clk);
		iv <= 1'b1;
		iw <= w;
		sa <= a;
		sb <= b;
		@(posedge clk);
		iv <= 1'b0;
		#1;
		cmp({62'h0, req, done}, {62'h0, e});
		if (e == 2'b10)
			exp_traps++;
	endtask
	task stop_test;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ====
	// scenarios
	task t_reg; // code field nonzero throughout, all ones except in the two unsigned cases
		ex(32'h0000fff2, M1, 64'h1, 2'b10);
		ex(32'h0000fff2, 64'h1, M1, 2'b01);
		ex(32'h0000ffb3, 64'h1, M1, 2'b10);
		ex(32'h0000ffb3, M1, 64'h1, 2'b01);
		ex(32'h0000fff6, 64'h5, 64'h5, 2'b01);
		ex(32'h0000fff6, 64'h5, 64'h4, 2'b10);
	endtask
	task t_imm; // source b carries junk: immediate forms must not use it
		ex(32'h040affff, M1 - 64'h1, 64'h0, 2'b10);
		ex(32'h040affff, 64'h0, M1, 2'b01);
		ex(32'h040b8000, 64'hffff_ffff_ffff_0000, M1, 2'b10);
		ex(32'h040b8000, 64'hffff_ffff_ffff_8000, 64'h0, 2'b01);
		ex(32'h040b7fff, 64'h8000, 64'h0, 2'b01);
		ex(32'h040b7fff, 64'h7ffe, 64'h0, 2'b10);
		ex(32'h040effff, M1, 64'h0, 2'b01);
		ex(32'h040effff, 64'hffff, M1, 2'b10);
		ex(32'h00000026, 64'h1, 64'h2, 2'b00);
	endtask
	task t_b2b; // back to back: two not-equal traps, then a completion
		@(posedge clk);
		iv <= 1'b1;
		iw <= 32'h00000036;
		sa <= 64'h1;
		sb <= 64'h2;
		@(posedge clk);
		sa <= 64'h3;
		#1;
		cmp({62'h0, req, done}, 64'h2);
		@(posedge clk);
		sa <= 64'h2;
		#1;
		cmp({62'h0, req, done}, 64'h2);
		@(posedge clk);
		iv <= 1'b0;
		#1;
		cmp({62'h0, req, done}, 64'h1);
		exp_traps += 2;
	endtask
	task t_none; // encodings outside the trap set give no answer at all
		ex(32'h0409ffff, 64'h0, 64'h0, 2'b00);
		ex(32'h38000000, 64'h1, 64'h2, 2'b00);
	endtask
	initial
		forever #25 clk = ~clk;
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reg();
		t_imm();
		t_b2b();
		t_none();
		repeat (2) @(posedge clk);
		cmp_count(traps, exp_traps);
		stop_test();
	end
endmodule
